/* File: rtl/epas_defs.vh */
// Purpose: Constants for the external port access sequencer
// Assumes: CLK runs at twice the peripheral clock rate
// Notes: One CLK cycle is one half peripheral clock
`ifndef EPAS_DEFS_VH
`define EPAS_DEFS_VH
// ----------------------------------------
// Widths
// ----------------------------------------
`define EPAS_AW 24
`define EPAS_DW 16
`define EPAS_WSW 3
// ----------------------------------------
// Lengthening modes
// ----------------------------------------
`define EPAS_MODE_WAIT 2'h1
`define EPAS_MODE_ACK 2'h2
`define EPAS_MODE_BOTH 2'h3
// ----------------------------------------
// Timing, in ns, peripheral clocks and CLK cycles
// ----------------------------------------
`define EPAS_CLK_NS 100
`define EPAS_PCLK_NS 200
`define EPAS_HALF_PCLK (`EPAS_PCLK_NS / 2 / `EPAS_CLK_NS)
`define EPAS_PCLK_CYC (`EPAS_PCLK_NS / `EPAS_CLK_NS)
`define EPAS_ACK_TAIL_PCLK 2
`define EPAS_ACK_TAIL_CYC (`EPAS_ACK_TAIL_PCLK * `EPAS_PCLK_CYC)
// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define EPAS_S_IDLE 3'h0
`define EPAS_S_SETUP 3'h1
`define EPAS_S_STROBE 3'h2
`define EPAS_S_ACKW 3'h3
`define EPAS_S_TAIL 3'h4
`define EPAS_S_HOLD 3'h5
`define EPAS_S_WHOLD 3'h6
`endif

/* File: rtl/epas_sync.v */
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to CLK
// Notes: Multi-bit use only for data held stable by the far side
module epas_sync #(
   parameter W = 1
) (
   input wire CLK,
   input wire RST,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_r;

   // ----------------------------------------
   // Synchroniser
   // ----------------------------------------
   always @(posedge CLK) begin
      if (RST) begin
         meta_r <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule // epas_sync

/* File: rtl/epas_top.v */
// Purpose: Sequences external port reads and writes with waitstates and acknowledge
// Assumes: CLK is twice the peripheral clock; peripheral clock is made here
// Notes: Memory select control settings arrive as plain inputs, sampled per access
`include "epas_defs.vh"

module epas_top (
   input wire CLK,
   input wire RST,
   input wire REQ,
   input wire REQ_WRITE,
   input wire [`EPAS_AW-1:0] REQ_ADDR,
   input wire [`EPAS_DW-1:0] REQ_WDATA,
   input wire [1:0] CTL_MODE,
   input wire [`EPAS_WSW-1:0] CTL_WAIT,
   input wire CTL_WRITE_HOLD_EXTEND,
   input wire ACK,
   input wire [`EPAS_DW-1:0] DATA_IN,
   output reg READY,
   output reg DONE,
   output reg [`EPAS_DW-1:0] RDATA,
   output reg PCLK_OUT,
   output reg CS_N,
   output reg [`EPAS_AW-1:0] ADDR,
   output reg RD_N,
   output reg WR_N,
   output reg [`EPAS_DW-1:0] DATA_OUT,
   output reg DATA_OE
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   wire ack_s;
   wire [`EPAS_DW-1:0] din_s;
   wire pclk_rise;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [4:0] cnt_r;
   reg [4:0] cnt_nxt;
   reg wr_r;
   reg ack_en_r;
   reg whc_r;
   reg ready_nxt;
   reg done_nxt;
   reg cs_n_nxt;
   reg rd_n_nxt;
   reg wr_n_nxt;
   reg oe_nxt;
   reg cap_nxt;
   wire [31:0] wait_cnt_init;
   wire [31:0] base_cnt_init;
   wire [31:0] tail_cnt_init;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   epas_sync #(.W(1)) u_ack_sync (
      .CLK(CLK),
      .RST(RST),
      .d(ACK),
      .q(ack_s)
   );

   epas_sync #(.W(`EPAS_DW)) u_din_sync (
      .CLK(CLK),
      .RST(RST),
      .d(DATA_IN),
      .q(din_s)
   );

   // ----------------------------------------
   // Peripheral clock divider
   // ----------------------------------------
   // The next edge raises the peripheral clock
   assign pclk_rise = ~PCLK_OUT;

   always @(posedge CLK) begin
      if (RST) begin
         PCLK_OUT <= 1'b0;
      end else begin
         PCLK_OUT <= ~PCLK_OUT;
      end
   end

   // ----------------------------------------
   // Counter loads
   // ----------------------------------------
   // Counters load one less than the length, since the zero count is the last cycle
   assign wait_cnt_init = ({29'h0, CTL_WAIT} + 32'h1) * `EPAS_PCLK_CYC - 32'h1;
   assign base_cnt_init = `EPAS_PCLK_CYC - 32'h1;
   assign tail_cnt_init = `EPAS_ACK_TAIL_CYC - 32'h1;

   // ----------------------------------------
   // Sequencer next state
   // ----------------------------------------
   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      ready_nxt = 1'b0;
      done_nxt = 1'b0;
      cs_n_nxt = CS_N;
      rd_n_nxt = RD_N;
      wr_n_nxt = WR_N;
      oe_nxt = DATA_OE;
      cap_nxt = 1'b0;
      case (state_r)
         `EPAS_S_IDLE: begin
            if (REQ && READY) begin
               cs_n_nxt = 1'b0;
               state_nxt = `EPAS_S_SETUP;
            end else begin
               ready_nxt = 1'b1;
            end
         end
         `EPAS_S_SETUP: begin
            // Strobe follows chip select by one half clock
            rd_n_nxt = wr_r;
            wr_n_nxt = ~wr_r;
            oe_nxt = wr_r;
            // Waitstates count only when the mode enables them
            if (CTL_MODE[0]) begin
               cnt_nxt = wait_cnt_init[4:0];
            end else begin
               cnt_nxt = base_cnt_init[4:0];
            end
            state_nxt = `EPAS_S_STROBE;
         end
         `EPAS_S_STROBE: begin
            if (cnt_r != 5'h0) begin
               cnt_nxt = cnt_r - 5'h1;
            end else if (ack_en_r) begin
               state_nxt = `EPAS_S_ACKW;
            end else begin
               rd_n_nxt = 1'b1;
               wr_n_nxt = 1'b1;
               cap_nxt = ~wr_r;
               state_nxt = `EPAS_S_HOLD;
            end
         end
         `EPAS_S_ACKW: begin
            // Acknowledge is only looked at on peripheral clock rises
            if (pclk_rise && ack_s) begin
               cnt_nxt = tail_cnt_init[4:0];
               state_nxt = `EPAS_S_TAIL;
            end
         end
         `EPAS_S_TAIL: begin
            if (cnt_r != 5'h0) begin
               cnt_nxt = cnt_r - 5'h1;
            end else begin
               rd_n_nxt = 1'b1;
               wr_n_nxt = 1'b1;
               cap_nxt = ~wr_r;
               state_nxt = `EPAS_S_HOLD;
            end
         end
         `EPAS_S_HOLD: begin
            // Chip select trails the strobe by one half clock; address holds until the next access
            cs_n_nxt = 1'b1;
            done_nxt = 1'b1;
            if (wr_r && whc_r) begin
               state_nxt = `EPAS_S_WHOLD;
            end else begin
               oe_nxt = 1'b0;
               state_nxt = `EPAS_S_IDLE;
            end
         end
         `EPAS_S_WHOLD: begin
            oe_nxt = 1'b0;
            state_nxt = `EPAS_S_IDLE;
         end
         default: begin
            cs_n_nxt = 1'b1;
            rd_n_nxt = 1'b1;
            wr_n_nxt = 1'b1;
            oe_nxt = 1'b0;
            state_nxt = `EPAS_S_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // Sequencer registers
   // ----------------------------------------
   always @(posedge CLK) begin
      if (RST) begin
         state_r <= `EPAS_S_IDLE;
         cnt_r <= 5'h0;
         wr_r <= 1'b0;
         ack_en_r <= 1'b0;
         whc_r <= 1'b0;
         READY <= 1'b0;
         DONE <= 1'b0;
         RDATA <= {`EPAS_DW{1'b0}};
         CS_N <= 1'b1;
         ADDR <= {`EPAS_AW{1'b0}};
         RD_N <= 1'b1;
         WR_N <= 1'b1;
         DATA_OUT <= {`EPAS_DW{1'b0}};
         DATA_OE <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         READY <= ready_nxt;
         DONE <= done_nxt;
         CS_N <= cs_n_nxt;
         RD_N <= rd_n_nxt;
         WR_N <= wr_n_nxt;
         DATA_OE <= oe_nxt;
         // Access settings are frozen for the whole access, except waitstate mode and count, read in SETUP
         if (state_r == `EPAS_S_IDLE && REQ && READY) begin
            wr_r <= REQ_WRITE;
            ack_en_r <= CTL_MODE[1];
            whc_r <= CTL_WRITE_HOLD_EXTEND;
            ADDR <= REQ_ADDR;
            DATA_OUT <= REQ_WDATA;
         end
         if (cap_nxt) begin
            RDATA <= din_s;
         end
      end
   end
endmodule // epas_top

/* File: bench/epas_properties.sv */
// Purpose: Port checks for epas_top
// Assumes: Controls stay stable over each access
// Notes: Strobe length counted in CLK cycles
`include "epas_defs.vh"
module epas_properties (
   input wire CLK,
   input wire RST,
   input wire ACK,
   input wire [1:0] CTL_MODE,
   input wire [`EPAS_WSW-1:0] CTL_WAIT,
   input wire CTL_WRITE_HOLD_EXTEND,
   input wire CS_N,
   input wire RD_N,
   input wire WR_N,
   input wire DATA_OE,
   input wire PCLK_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   wire strb = !RD_N || !WR_N;
   reg [7:0] len_r;
   always @(posedge CLK) len_r <= strb ? len_r + 8'h01 : 8'h00;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   cs_lead_a: assert property ($rose(strb) |-> !$past(CS_N)) else $error("cs lead");
   cs_trail_a: assert property ($fell(strb) |-> !CS_N ##1 CS_N) else $error("cs trail");
   strobe_gap_a: assert property ($fell(strb) |-> !strb [*3]) else $error("gap");
   strobe_len_a: assert property ($fell(strb) && !CTL_MODE[1] |->
      len_r == (CTL_MODE[0] ? 2 * (CTL_WAIT + 1) : 2)) else $error("len");
   ack_stall_a: assert property ($rose(strb) && CTL_MODE[1] && !ACK |-> strb [*6])
      else $error("ack stall");
   ack_tail_a: assert property ($rose(ACK) && strb && CTL_MODE == `EPAS_MODE_ACK |->
      strb [*5] ##[1:5] !strb) else $error("ack tail");
   whold_on_a: assert property ($rose(WR_N) && CTL_WRITE_HOLD_EXTEND |->
      DATA_OE ##1 DATA_OE ##1 !DATA_OE) else $error("hold on");
   whold_off_a: assert property ($rose(WR_N) && !CTL_WRITE_HOLD_EXTEND |->
      DATA_OE ##1 !DATA_OE) else $error("hold off");
   pclk_toggle_a: assert property (!$past(RST) |-> PCLK_OUT != $past(PCLK_OUT))
      else $error("pclk stuck");
   cover property ($fell(strb) && CTL_MODE[1]);
   cover property ($rose(WR_N) && CTL_WRITE_HOLD_EXTEND);
   cover property ($fell(strb) && CTL_WAIT == 3'h7);
endmodule // epas_properties
bind epas_top epas_properties u_props (.CLK(CLK), .RST(RST), .ACK(ACK), .CTL_MODE(CTL_MODE),
   .CTL_WAIT(CTL_WAIT), .CTL_WRITE_HOLD_EXTEND(CTL_WRITE_HOLD_EXTEND), .CS_N(CS_N),
   .RD_N(RD_N), .WR_N(WR_N), .DATA_OE(DATA_OE), .PCLK_OUT(PCLK_OUT));

/* File: bench/epas_mem_model.sv */
// Purpose: Far-side memory with a slow acknowledge
// Assumes: Acknowledge rises stall+1 CLKs after select
// Notes: Released data lines toggle every cycle
`include "epas_defs.vh"
module epas_mem_model (
   input wire clk,
   input wire cs_n,
   input wire [`EPAS_AW-1:0] addr,
   input wire wr_n,
   input wire [`EPAS_DW-1:0] wdata,
   input wire [7:0] stall,
   output logic ack,
   output wire [`EPAS_DW-1:0] rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [`EPAS_DW-1:0] mem [0:15];
   logic [`EPAS_DW-1:0] alt = 16'h0;
   logic [7:0] cnt = 8'h00;
   initial ack = 1'b0;
   // No stale value is left on released lines
   assign rdata = (!cs_n && wr_n) ? mem[addr[3:0]] : alt;
   always @(posedge clk) begin
      alt <= ~rdata;
      cnt <= cs_n ? 8'h00 : cnt + 8'h01;
      ack <= !cs_n && cnt >= stall;
   end
   always @(posedge wr_n) if (!cs_n) mem[addr[3:0]] <= wdata;
endmodule // epas_mem_model

/* File: bench/epas_top_bench.sv */
// Purpose: Self-checking bench for epas_top
// Assumes: Far side is epas_mem_model
// Notes: Inputs change 1 ns after each rising edge
`include "epas_defs.vh"
module epas_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic REQ = 1'b0;
   logic REQ_WRITE = 1'b0;
   logic [`EPAS_AW-1:0] REQ_ADDR = 24'h0;
   logic [`EPAS_DW-1:0] REQ_WDATA = 16'h0;
   logic [1:0] CTL_MODE = 2'h0;
   logic [`EPAS_WSW-1:0] CTL_WAIT = 3'h0;
   logic CTL_WRITE_HOLD_EXTEND = 1'b0;
   logic [7:0] stall = 8'h00;
   wire ACK, READY, DONE, PCLK_OUT, CS_N, RD_N, WR_N, DATA_OE;
   wire [`EPAS_DW-1:0] DATA_IN, RDATA, DATA_OUT;
   wire [`EPAS_AW-1:0] ADDR;
   int n_errors = 0;
   int n_checks = 0;
   epas_top dut (.CLK(CLK), .RST(RST), .REQ(REQ), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
      .REQ_WDATA(REQ_WDATA), .CTL_MODE(CTL_MODE), .CTL_WAIT(CTL_WAIT),
      .CTL_WRITE_HOLD_EXTEND(CTL_WRITE_HOLD_EXTEND), .ACK(ACK), .DATA_IN(DATA_IN),
      .READY(READY), .DONE(DONE), .RDATA(RDATA), .PCLK_OUT(PCLK_OUT), .CS_N(CS_N),
      .ADDR(ADDR), .RD_N(RD_N), .WR_N(WR_N), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE));
   epas_mem_model far_side (.clk(CLK), .cs_n(CS_N), .addr(ADDR), .wr_n(WR_N),
      .wdata(DATA_OUT), .stall(stall), .ack(ACK), .rdata(DATA_IN));
   initial forever #50 CLK = ~CLK;
   task automatic step;
      @(posedge CLK);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // One access; address from the low nibble of the data
   task automatic access(input logic wr, input logic [15:0] d, output logic [15:0] q,
      output logic [15:0] len);
      int i;
      len = 16'h0;
      REQ = 1'b1;
      REQ_WRITE = wr;
      REQ_ADDR = {20'h0, d[3:0]};
      REQ_WDATA = d;
      for (i = 0; i < 40 && READY !== 1'b1; i++) step();
      if (i >= 40) begin
         n_errors++;
         $display("ERROR %0t: not ready", $time);
         end_sim();
      end
      step();
      REQ = 1'b0;
      for (i = 0; i < 300 && DONE !== 1'b1; i++) begin
         if (RD_N === 1'b0 || WR_N === 1'b0) len++;
         step();
      end
      q = RDATA;
      if (i >= 300) begin
         n_errors++;
         $display("ERROR %0t: timeout", $time);
         end_sim();
      end
   endtask
   // Write then read back; with acknowledge the clock phase leaves one cycle of doubt
   task automatic xfer(input logic [1:0] m, input logic [2:0] w, input logic h,
      input logic [7:0] s, input logic [15:0] d, input logic [15:0] el);
      logic [15:0] q, len;
      CTL_MODE = m;
      CTL_WAIT = w;
      CTL_WRITE_HOLD_EXTEND = h;
      stall = s;
      access(1'b1, d, q, len);
      chk({15'h0, DATA_OE}, {15'h0, h});
      if (m[1]) chk({15'h0, len >= el && len <= el + 16'h1}, 16'h1);
      else chk(len, el);
      access(1'b0, d, q, len);
      chk(q, d);
      if (m[1]) chk({15'h0, len >= el && len <= el + 16'h1}, 16'h1);
      else chk(len, el);
   endtask
   task automatic sc_waits;
      xfer(2'h0, 3'h7, 1'b0, 8'h00, 16'hA5C1, 16'h2);
      xfer(`EPAS_MODE_WAIT, 3'h0, 1'b0, 8'h00, 16'h5A32, 16'h2);
      xfer(`EPAS_MODE_WAIT, 3'h7, 1'b0, 8'h00, 16'hFFF3, 16'h10);
   endtask
   task automatic sc_ack;
      xfer(`EPAS_MODE_ACK, 3'h0, 1'b0, 8'h0C, 16'h1234, 16'h13);
      xfer(`EPAS_MODE_ACK, 3'h0, 1'b0, 8'h00, 16'h8E47, 16'h7);
      xfer(`EPAS_MODE_BOTH, 3'h2, 1'b0, 8'h10, 16'h0F05, 16'h17);
   endtask
   task automatic sc_hold;
      xfer(`EPAS_MODE_WAIT, 3'h1, 1'b1, 8'h00, 16'hC3C6, 16'h4);
   endtask
   initial begin
      repeat (16) @(posedge CLK);
      #1;
      RST = 1'b0;
      step();
      step();
      sc_waits();
      sc_ack();
      sc_hold();
      end_sim();
   end
endmodule // epas_top_bench
